// >>> src/sacc_pkg.sv
// shared constants for the simultaneous conversion control block
// assumes an apb slave on sys_clk and pins sampled through two flip-flops
// Functional notes
// R1 - a rising trigger edge samples all inputs of its group at once
// R2 - conversion runs on an internal clock, derived here, never from the host
// R3 - busy falls only after every channel of the cycle is converted
// R4 - when busy falls the hold stages return to tracking
// R5 - each new rising trigger edge starts a fresh sample and convert cycle; here edges while busy only raise the missed event
// R6 - every result is a twos complement signed value
// R7 - span pin high selects plus-minus 10 V, low selects plus-minus 5 V
// R8 - host must pulse reset after power-up before converting
// R9 - reference pin high enables internal 2.5 V reference, low selects external
// R10 - every reset re-samples the reference and span pins
// R11 - inputs beyond the span give the saturated full-scale code
// R12 - serial readout: select falling drives the first-channel flag high
// R13 - serial readout: flag goes low after the 16th serial clock falling edge
// R14 - parallel readout: flag high on first read strobe fall, low on next
// R15 - select rising returns the first-channel flag to high impedance
// R16 - trigger a covers channels one to four, trigger b five to eight
// R17 - busy rises once both triggers have had a rising edge
// R18 - host must not start reading at the busy falling edge
// R19 - sixteen-bit results in ascending channel order, flag marks channel one
package sacc_pkg;
  localparam int NUM_CH = 8;
  localparam int GROUP_CH = 4;
  localparam int RES_W = 16;
  localparam int MV_W = 16;
  localparam int SPAN10_MV = 10000;
  localparam int SPAN5_MV = 5000;
  localparam int FULL_SHIFT = 15;
  localparam logic [RES_W-1:0] CODE_POS_FS = 16'h7fff;
  localparam logic [RES_W-1:0] CODE_NEG_FS = 16'h8000;
  localparam logic [3:0] BITS_PER_WORD_M1 = 4'hf;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_RESULT0 = 8'h10;
  localparam logic [7:0] OFF_LAST = 8'h2c;

  // control bits
  localparam int CTRL_ENABLE = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_TRACK = 1;
  localparam int ST_SPAN10 = 2;
  localparam int ST_REFINT = 3;
  localparam int ST_ARMED_A = 4;
  localparam int ST_ARMED_B = 5;
  // interrupt event bits
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_OVER = 1;
  localparam int EV_MISSED = 2;

  // synchronised pin positions
  localparam int PIN_W = 8;
  localparam int P_TRIG_A = 0;
  localparam int P_TRIG_B = 1;
  localparam int P_SEL_N = 2;
  localparam int P_RD_N = 3;
  localparam int P_SCLK = 4;
  localparam int P_SPAN = 5;
  localparam int P_REFSEL = 6;
  localparam int P_SERIAL = 7;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [1:0] {
    SACC_TRACK = 2'b00,
    SACC_CONV = 2'b01,
    SACC_DONE = 2'b11
  } sacc_state_t;
endpackage

// >>> src/sacc_quant.sv
// quantiser for one channel: held millivolt value to a signed result code
// assumes a stable sample and a span strap that only changes at reset
module sacc_quant (
  input wire logic signed [sacc_pkg::MV_W-1:0] sample_mv,
  input wire logic span10,
  output logic [sacc_pkg::RES_W-1:0] code,
  output logic over
);
  import sacc_pkg::*;

  logic signed [31:0] span_mv;
  logic signed [31:0] wide_mv;
  logic signed [31:0] quot;

  always_comb begin
    span_mv = span10 ? 32'(SPAN10_MV) : 32'(SPAN5_MV); // R7
    wide_mv = 32'(sample_mv);
    quot = (wide_mv <<< FULL_SHIFT) / span_mv;
    over = (wide_mv > span_mv) || (wide_mv < -span_mv);
    if (wide_mv >= span_mv) begin
      code = CODE_POS_FS; // R11
    end else if (wide_mv <= -span_mv) begin
      code = CODE_NEG_FS; // R11
    end else begin
      code = quot[RES_W-1:0]; // R6
    end
  end
endmodule

// >>> src/sacc_top.sv
// sequencing, readout and apb register file of the eight-channel converter
// assumes pins come from outside sys_clk; analog inputs modelled as millivolts
module sacc_top #(
  parameter int CONV_DIV = 4,
  parameter int TICKS_PER_CH = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic trigger_group_low_channels,
  input wire logic trigger_group_high_channels,
  input wire logic select_line_low,
  input wire logic read_strobe_low,
  input wire logic serial_clock,
  input wire logic span_select,
  input wire logic ref_source_select,
  input wire logic serial_mode,
  input wire logic [sacc_pkg::NUM_CH*sacc_pkg::MV_W-1:0] ain_mv,
  output logic busy,
  output logic track_mode,
  output logic span_10v,
  output logic ref_internal_en,
  output logic [sacc_pkg::RES_W-1:0] db_out,
  output logic db_oe_n,
  output logic dout_a,
  output logic dout_b,
  output logic dout_oe_n,
  output logic first_channel_flag,
  output logic first_channel_flag_oe_n
);
  import sacc_pkg::*;

  if (CONV_DIV < 1 || CONV_DIV > 255 || TICKS_PER_CH < 1 || TICKS_PER_CH > 255) begin : g_bad_cfg
    $error("sacc_top: divider or tick count out of range");
  end

  localparam logic [7:0] DIV_M1 = 8'(CONV_DIV - 1);
  localparam logic [7:0] TICK_M1 = 8'(TICKS_PER_CH - 1);
  localparam logic [2:0] LAST_CH = 3'(NUM_CH - 1);
  localparam logic [1:0] LAST_GRP = 2'(GROUP_CH - 1);
  // strobes idle high, so reset to that level and no false edge follows reset
  localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'((1 << P_SEL_N) | (1 << P_RD_N));

  function automatic logic is_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  function automatic logic is_fall(input logic now, input logic prev);
    return ~now & prev;
  endfunction

  // pin synchronisers; stage one feeds only stage two
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_d_r;
  logic [NUM_CH*MV_W-1:0] ain_s1_r;
  logic [NUM_CH*MV_W-1:0] ain_s2_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_d_r <= PIN_IDLE;
      ain_s1_r <= '0;
      ain_s2_r <= '0;
    end else begin
      pin_s1_r <= {serial_mode, ref_source_select, span_select, serial_clock,
                   read_strobe_low, select_line_low, trigger_group_high_channels,
                   trigger_group_low_channels};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      ain_s1_r <= ain_mv;
      ain_s2_r <= ain_s1_r;
    end
  end

  logic rise_a, rise_b, sel_fall, sel_rise, rd_fall, sclk_rise, sclk_fall, sel_low, ser;
  assign rise_a = is_rise(pin_s2_r[P_TRIG_A], pin_d_r[P_TRIG_A]);
  assign rise_b = is_rise(pin_s2_r[P_TRIG_B], pin_d_r[P_TRIG_B]);
  assign sel_fall = is_fall(pin_s2_r[P_SEL_N], pin_d_r[P_SEL_N]);
  assign sel_rise = is_rise(pin_s2_r[P_SEL_N], pin_d_r[P_SEL_N]);
  assign rd_fall = is_fall(pin_s2_r[P_RD_N], pin_d_r[P_RD_N]);
  assign sclk_rise = is_rise(pin_s2_r[P_SCLK], pin_d_r[P_SCLK]);
  assign sclk_fall = is_fall(pin_s2_r[P_SCLK], pin_d_r[P_SCLK]);
  assign sel_low = ~pin_s2_r[P_SEL_N];
  assign ser = pin_s2_r[P_SERIAL];

  // straps taken a fixed time after reset release, once synchronised
  logic [1:0] strap_cnt_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_r <= '0;
      span_10v <= 1'b0;
      ref_internal_en <= 1'b0;
    end else if (strap_cnt_r != STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT - 2'h1) begin
        span_10v <= pin_s2_r[P_SPAN]; // R7 R10
        ref_internal_en <= pin_s2_r[P_REFSEL]; // R9 R10
      end
    end
  end

  // registers
  logic [31:0] ctrl_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [EV_W-1:0] ev_set;
  logic wr_en, rd_en, addr_ok;
  assign addr_ok = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= OFF_LAST);
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;

  // internal conversion clock enable
  logic [7:0] div_r;
  logic conv_tick;
  assign conv_tick = (div_r == DIV_M1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
    end else begin
      div_r <= conv_tick ? 8'h0 : div_r + 8'h1; // R2
    end
  end

  // quantisers
  logic signed [MV_W-1:0] held_r [NUM_CH];
  logic [RES_W-1:0] code [NUM_CH];
  logic [NUM_CH-1:0] over;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      sacc_quant u_quant (
        .sample_mv(held_r[g]),
        .span10(span_10v),
        .code(code[g]),
        .over(over[g])
      );
    end
  endgenerate

  // conversion sequencer
  sacc_state_t state_r;
  logic armed_a_r, armed_b_r;
  logic [2:0] ch_r;
  logic [7:0] tick_r;
  logic over_acc_r;
  logic [RES_W-1:0] conv_r [NUM_CH];
  logic [RES_W-1:0] out_r [NUM_CH];
  logic done_pulse;
  logic start_ok;
  assign start_ok = ctrl_r[CTRL_ENABLE] && (state_r == SACC_TRACK);
  assign done_pulse = (state_r == SACC_DONE);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SACC_TRACK;
      armed_a_r <= 1'b0;
      armed_b_r <= 1'b0;
      ch_r <= '0;
      tick_r <= '0;
      over_acc_r <= 1'b0;
      busy <= 1'b0;
      track_mode <= 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        held_r[i] <= '0;
        conv_r[i] <= '0;
        out_r[i] <= '0;
      end
    end else begin
      case (state_r)
        SACC_TRACK: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if ((i < GROUP_CH && rise_a && start_ok && !armed_a_r) ||
                (i >= GROUP_CH && rise_b && start_ok && !armed_b_r)) begin
              held_r[i] <= ain_s2_r[i*MV_W +: MV_W]; // R1 R16
            end
          end
          if (start_ok && rise_a) begin
            armed_a_r <= 1'b1; // R16
          end
          if (start_ok && rise_b) begin
            armed_b_r <= 1'b1; // R16
          end
          if (start_ok && (rise_a || rise_b)) begin
            track_mode <= 1'b0;
          end
          if ((armed_a_r || rise_a) && (armed_b_r || rise_b) && start_ok) begin
            busy <= 1'b1; // R17
            state_r <= SACC_CONV;
            ch_r <= '0;
            tick_r <= '0;
            over_acc_r <= 1'b0;
          end
        end
        SACC_CONV: begin
          if (conv_tick) begin
            if (tick_r == TICK_M1) begin
              tick_r <= '0;
              conv_r[ch_r] <= code[ch_r]; // R2 R6
              over_acc_r <= over_acc_r | over[ch_r];
              if (ch_r == LAST_CH) begin
                state_r <= SACC_DONE;
              end else begin
                ch_r <= ch_r + 3'h1;
              end
            end else begin
              tick_r <= tick_r + 8'h1;
            end
          end
        end
        SACC_DONE: begin
          busy <= 1'b0; // R3
          track_mode <= 1'b1; // R4
          armed_a_r <= 1'b0; // R5
          armed_b_r <= 1'b0;
          state_r <= SACC_TRACK;
          for (int i = 0; i < NUM_CH; i++) begin
            out_r[i] <= conv_r[i]; // output data updated as busy falls
          end
        end
        default: state_r <= SACC_TRACK;
      endcase
    end
  end

  // readout; pointers restart whenever a new set of results lands
  logic [2:0] par_ptr_r;
  logic [1:0] ser_word_r;
  logic [3:0] bit_cnt_r;
  logic [RES_W-1:0] sh_a_r, sh_b_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      par_ptr_r <= '0;
      ser_word_r <= '0;
      bit_cnt_r <= '0;
      sh_a_r <= '0;
      sh_b_r <= '0;
      db_out <= '0;
      db_oe_n <= 1'b1;
      dout_a <= 1'b0;
      dout_b <= 1'b0;
      dout_oe_n <= 1'b1;
      first_channel_flag <= 1'b0;
      first_channel_flag_oe_n <= 1'b1;
    end else if (sel_rise) begin
      first_channel_flag_oe_n <= 1'b1; // R15
      db_oe_n <= 1'b1;
      dout_oe_n <= 1'b1;
      // a frame may end in the very cycle fresh results land
      if (done_pulse) begin
        par_ptr_r <= '0;
        ser_word_r <= '0;
        bit_cnt_r <= '0;
      end
    end else if (done_pulse) begin
      par_ptr_r <= '0; // R19
      ser_word_r <= '0;
      bit_cnt_r <= '0;
    end else if (sel_fall) begin
      first_channel_flag_oe_n <= 1'b0;
      bit_cnt_r <= '0;
      if (ser) begin
        dout_oe_n <= 1'b0;
        first_channel_flag <= (ser_word_r == 2'h0); // R12
        sh_a_r <= out_r[ser_word_r] << 1;
        sh_b_r <= out_r[3'(ser_word_r) + 3'(GROUP_CH)] << 1;
        dout_a <= out_r[ser_word_r][RES_W-1];
        dout_b <= out_r[3'(ser_word_r) + 3'(GROUP_CH)][RES_W-1];
      end else begin
        db_oe_n <= 1'b0;
        first_channel_flag <= 1'b0;
      end
    end else if (sel_low && !ser && rd_fall) begin
      db_out <= out_r[par_ptr_r]; // R19
      first_channel_flag <= (par_ptr_r == 3'h0); // R14
      par_ptr_r <= par_ptr_r + 3'h1;
    end else if (sel_low && ser && sclk_rise) begin
      dout_a <= sh_a_r[RES_W-1];
      dout_b <= sh_b_r[RES_W-1];
      sh_a_r <= sh_a_r << 1;
      sh_b_r <= sh_b_r << 1;
    end else if (sel_low && ser && sclk_fall) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == BITS_PER_WORD_M1) begin
        first_channel_flag <= 1'b0; // R13
        ser_word_r <= (ser_word_r == LAST_GRP) ? 2'h0 : ser_word_r + 2'h1;
        // next word is loaded now so its msb leads the 17th rising edge
        sh_a_r <= out_r[3'(ser_word_r + 2'h1) & 3'h3] << 1;
        sh_b_r <= out_r[(3'(ser_word_r + 2'h1) & 3'h3) + 3'(GROUP_CH)] << 1;
        dout_a <= out_r[3'(ser_word_r + 2'h1) & 3'h3][RES_W-1];
        dout_b <= out_r[(3'(ser_word_r + 2'h1) & 3'h3) + 3'(GROUP_CH)][RES_W-1];
      end
    end
  end

  // interrupt events; a set in the clearing cycle wins
  assign ev_set[EV_DONE] = done_pulse;
  assign ev_set[EV_OVER] = done_pulse & over_acc_r;
  assign ev_set[EV_MISSED] = (rise_a | rise_b) & (state_r != SACC_TRACK);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      ctrl_r <= CTRL_RESET;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr[7:0] == OFF_IRQ_STAT) ?
                    pwdata[EV_W-1:0] : {EV_W{1'b0}})) | ev_set;
      if (wr_en && paddr[7:0] == OFF_IRQ_MASK) begin
        irq_mask_r <= pwdata[EV_W-1:0];
      end
      if (wr_en && paddr[7:0] == OFF_CTRL) begin
        ctrl_r <= pwdata & CTRL_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // apb: no wait state, read data captured in setup, answer in access
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    case (paddr[7:0])
      OFF_CTRL: rd_val = ctrl_r;
      OFF_STATUS: begin
        rd_val[ST_BUSY] = busy;
        rd_val[ST_TRACK] = track_mode;
        rd_val[ST_SPAN10] = span_10v;
        rd_val[ST_REFINT] = ref_internal_en;
        rd_val[ST_ARMED_A] = armed_a_r;
        rd_val[ST_ARMED_B] = armed_b_r;
      end
      OFF_IRQ_STAT: rd_val[EV_W-1:0] = irq_stat_r;
      OFF_IRQ_MASK: rd_val[EV_W-1:0] = irq_mask_r;
      default: begin
        if (addr_ok && paddr[7:0] >= OFF_RESULT0) begin
          rd_val[RES_W-1:0] = out_r[3'((paddr[7:0] - OFF_RESULT0) >> 2)];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        prdata <= addr_ok ? rd_val : 32'h0;
      end
    end
  end
endmodule

// >>> verif/sacc_top_sva.sv
// checker for the conversion control top, sys_clk domain only
// assumes straps are held steady across every reset release
module sacc_top_chk #(
  parameter int CONV_DIV = 4,
  parameter int TICKS_PER_CH = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic busy,
  input wire logic track_mode,
  input wire logic span_select,
  input wire logic ref_source_select,
  input wire logic span_10v,
  input wire logic ref_internal_en,
  input wire logic serial_mode,
  input wire logic select_line_low,
  input wire logic first_channel_flag,
  input wire logic first_channel_flag_oe_n,
  input wire logic db_oe_n,
  input wire logic dout_oe_n
);
  // slack covers the divider alignment at the start of a cycle
  localparam int BMAX = 8 * TICKS_PER_CH * CONV_DIV + 2 * CONV_DIV + 8;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_busy_after_track; $rose(busy) |-> !track_mode; endproperty
  property p_track_on_fall; $fell(busy) |-> track_mode; endproperty
  property p_no_track_busy; !(busy && track_mode); endproperty
  property p_busy_len; $rose(busy) |=> busy[*8] ##[1:BMAX] !busy; endproperty
  property p_flag_drive;
    $fell(select_line_low) |->
      ##[1:5] (!first_channel_flag_oe_n &&
      (serial_mode ? (first_channel_flag && !dout_oe_n) : !db_oe_n));
  endproperty
  property p_flag_hiz;
    $rose(select_line_low) |-> ##[1:5] (first_channel_flag_oe_n && db_oe_n && dout_oe_n);
  endproperty
  property p_strap;
    $rose(resetn) |-> ##3 (span_10v == span_select && ref_internal_en == ref_source_select);
  endproperty
  property p_apb_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_busy_after_track: assert property (p_busy_after_track)
    else $error("busy rose while tracking");
  a_track_on_fall: assert property (p_track_on_fall)
    else $error("no tracking when busy fell");
  a_no_track_busy: assert property (p_no_track_busy)
    else $error("tracking during conversion");
  a_busy_len: assert property (p_busy_len)
    else $error("busy length out of range");
  a_flag_drive: assert property (p_flag_drive)
    else $error("flag not driven after select fall");
  a_flag_hiz: assert property (p_flag_hiz)
    else $error("flag not released after select rise");
  a_strap: assert property (p_strap)
    else $error("strap levels not captured");
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb answer late or long");
  c_conv: cover property ($fell(busy));
  c_ser: cover property (serial_mode && $fell(first_channel_flag));
  c_par: cover property (!serial_mode && $rose(first_channel_flag));
endmodule

bind sacc_top sacc_top_chk #(.CONV_DIV(CONV_DIV), .TICKS_PER_CH(TICKS_PER_CH)) i_chk (
  .sys_clk, .resetn, .psel, .penable, .pready, .busy, .track_mode, .span_select,
  .ref_source_select, .span_10v, .ref_internal_en, .serial_mode, .select_line_low,
  .first_channel_flag, .first_channel_flag_oe_n, .db_oe_n, .dout_oe_n);

// >>> verif/sacc_host_model.sv
// host controller model: trigger pulses, parallel and serial readout frames
// assumes device pins are asynchronous; actions sit 7 ns after a clock edge
module sacc_host_model (
  input wire logic sys_clk,
  input wire logic [15:0] db_out,
  input wire logic dout_a,
  input wire logic dout_b,
  input wire logic first_channel_flag,
  output logic trig_a,
  output logic trig_b,
  output logic sel_n,
  output logic rd_n,
  output logic sclk,
  output logic [32:0] word,
  output logic word_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {trig_a, trig_b, sel_n, rd_n, sclk, word_ok} = 6'h0c;
    word = 33'h0;
  end
  task automatic emit(input logic [32:0] v);
    word = v;
    word_ok = 1'b1;
    @(posedge sys_clk);
    #7 word_ok = 1'b0;
  endtask
  task automatic convert();
    #7 trig_a = 1'b1;
    #200 trig_b = 1'b1;
    #400 trig_a = 1'b0;
    trig_b = 1'b0;
  endtask
  task automatic par_read();
    #7 sel_n = 1'b0;
    #200;
    repeat (8) begin
      rd_n = 1'b0;
      #200 emit({first_channel_flag, 16'h0, db_out});
      rd_n = 1'b1;
      #160;
    end
    sel_n = 1'b1;
  endtask
  // serial clock stands still outside the frame
  task automatic ser_read();
    logic [32:0] v;
    #7 sel_n = 1'b0;
    #200;
    repeat (4) begin
      v[32] = first_channel_flag;
      for (int i = 15; i >= 0; i--) begin
        v[16 + i] = dout_a;
        v[i] = dout_b;
        sclk = 1'b1;
        #160 sclk = 1'b0;
        #160;
      end
      emit(v);
    end
    sel_n = 1'b1;
  endtask
endmodule

// >>> verif/tb_simultaneous_adc_conversion_control.sv
// self-checking bench: apb master, host model, queue of expected results
// assumes the top module at its default conversion timing
module tb_simultaneous_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  import sacc_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, span_select;
  logic ref_source_select, serial_mode, busy, track_mode, trig_a, trig_b, sel_n, rd_n;
  logic sclk, dout_a, dout_b, fcf, word_ok;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] db_out;
  logic [32:0] word;
  logic [NUM_CH*MV_W-1:0] ain_mv;
  logic [32:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'h2a85;
  int mv[NUM_CH];
  sacc_top i_dut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .irq, .trigger_group_low_channels(trig_a),
    .trigger_group_high_channels(trig_b), .select_line_low(sel_n), .read_strobe_low(rd_n),
    .serial_clock(sclk), .span_select, .ref_source_select, .serial_mode, .ain_mv, .busy,
    .track_mode, .span_10v(), .ref_internal_en(), .db_out, .db_oe_n(), .dout_a, .dout_b,
    .dout_oe_n(), .first_channel_flag(fcf), .first_channel_flag_oe_n());
  sacc_host_model i_host (.sys_clk, .db_out, .dout_a, .dout_b, .first_channel_flag(fcf),
    .trig_a, .trig_b, .sel_n, .rd_n, .sclk, .word, .word_ok);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic seen(input string what, input logic [32:0] got);
    logic [32:0] e;
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask
  always @(posedge sys_clk) begin
    if (word_ok) seen("readout word", word);
    if (psel && penable && pready && !pwrite) seen("apb read", {pslverr, prdata});
  end
  task automatic now(input string what, input logic [32:0] e, input logic [32:0] got);
    exp_q.push_back(e);
    seen(what, got);
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready taken as sampled at each rising edge; only the watchdog ends a stuck wait
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [15:0] code_of(input int v, input logic s10);
    int span;
    span = s10 ? SPAN10_MV : SPAN5_MV;
    if (v >= span) return CODE_POS_FS;
    if (v <= -span) return CODE_NEG_FS;
    return 16'((v * 32768) / span);
  endfunction
  task automatic conv_cycle(input logic s10);
    int span;
    span = s10 ? SPAN10_MV : SPAN5_MV;
    @(posedge sys_clk);
    for (int i = 0; i < NUM_CH; i++) begin
      mv[i] = $random(seed) % span;
      if (i == 3) mv[i] = -span - 1;
      if (i == 7) mv[i] = span;
      ain_mv[i * MV_W +: MV_W] <= 16'(mv[i]);
    end
    repeat (3) @(posedge sys_clk);
    i_host.convert();
    now("busy raised", 33'h1, 33'(busy));
    while (busy !== 1'b0) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask
  initial begin
    {psel, penable, pwrite, serial_mode, ref_source_select, resetn} = 6'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ain_mv = '0;
    span_select = 1'b1;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(32'(OFF_CTRL), 33'h1);
    rd(32'(OFF_STATUS), 33'h6);
    rd(32'(OFF_IRQ_MASK), 33'h0);
    rd(32'h30, {1'b1, 32'h0});
    apb(1'b1, 32'(OFF_IRQ_MASK), 32'h1);
    conv_cycle(1'b1);
    now("irq raised", 33'h1, 33'(irq));
    rd(32'(OFF_IRQ_STAT), 33'h3);
    apb(1'b1, 32'(OFF_IRQ_STAT), 32'h3);
    repeat (2) @(negedge sys_clk);
    now("irq cleared", 33'h0, 33'(irq));
    for (int i = 0; i < NUM_CH; i++) begin
      rd(32'(OFF_RESULT0) + 32'(4 * i), {17'h0, code_of(mv[i], 1'b1)});
    end
    for (int i = 0; i < NUM_CH; i++) begin
      exp_q.push_back({i == 0, 16'h0, code_of(mv[i], 1'b1)});
    end
    i_host.par_read();
    @(posedge sys_clk);
    resetn <= 1'b0;
    span_select <= 1'b0;
    ref_source_select <= 1'b1;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(32'(OFF_STATUS), 33'ha);
    apb(1'b1, 32'(OFF_CTRL), 32'h0);
    i_host.convert();
    now("busy while disabled", 33'h0, 33'(busy));
    apb(1'b1, 32'(OFF_CTRL), 32'h1);
    serial_mode <= 1'b1;
    conv_cycle(1'b0);
    conv_cycle(1'b0);
    now("irq masked", 33'h0, 33'(irq));
    rd(32'(OFF_IRQ_STAT), 33'h3);
    for (int i = 0; i < GROUP_CH; i++) begin
      exp_q.push_back({i == 0, code_of(mv[i], 1'b0), code_of(mv[i + 4], 1'b0)});
    end
    i_host.ser_read();
    repeat (8) @(posedge sys_clk);
    n_compared++;
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("wrong value pending notes expected 0 seen %0d", exp_q.size());
    end
    complete_run();
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    complete_run();
  end
endmodule
